// >>> core/pin_state_map.vh
// Purpose: Constants for the pin state and mode controller.
// Assumes: 100 MHz system clock.
// Notes: Bus T-state and standby codes are local encodings.
`ifndef PIN_STATE_MAP_VH
`define PIN_STATE_MAP_VH

// Power-on settling time and clock rate
`define PSM_POR_TIME_MS 1
`define PSM_CLK_MHZ 100
`define PSM_POR_CYCLES (`PSM_POR_TIME_MS * `PSM_CLK_MHZ * 1000)

// Bus T-state codes reported by the bus controller
`define PSM_T1 2'h0
`define PSM_T2 2'h1
`define PSM_T3 2'h2
`define PSM_TW 2'h3

// Standby request codes
`define PSM_SB_RUN 2'h0
`define PSM_SB_HALT 2'h1
`define PSM_SB_IDLE 2'h2
`define PSM_SB_STOP 2'h3

// Controller state codes
`define PSM_ST_POWER_ON 3'h0
`define PSM_ST_EXT_RESET 3'h1
`define PSM_ST_INT_RESET 3'h2
`define PSM_ST_RUN 3'h3
`define PSM_ST_HALT 3'h4
`define PSM_ST_IDLE 3'h5
`define PSM_ST_STOP 3'h6
`define PSM_ST_HOLD 3'h7

`endif

// >>> core/pin_state_mode_control.v
// Purpose: Chooses the level and drive of bus, debug, analog and port pins
//   for power-on, reset, standby, bus idle and bus hold.
// Assumes: Core-side inputs are on CLK_SYS_I; pin inputs are asynchronous.
// Notes: All pin outputs are registered, one cycle behind their decode;
//   output enables are active low.
`timescale 1ns/1ns
`include "pin_state_map.vh"

// Operation
// - Pins stay in the power-on state until 1 ms after supply is good.
// - In standby a pin whose alternate function is active keeps working.
// - Bus idle after T2 (separate) or T3 (multiplexed) keeps strobes high and holds selects and bus.
// - Debug reset pulls down at power-on and external reset, per bit in run and internal reset; standby and hold keep it.
// - Debug data pin floats in reset and in run outside debug mode; standby and hold keep its drive.
// - Any reset leaves bus control, address and data pins floating.
// - Halt keeps the bus running under DMA, else strobes and selects high.
// - Halt floats address/data in separate mode, address pins undefined.
// - Held pins keep the level of the preceding external bus cycle.
// - Wait and hold-request inputs are ignored where sampling is barred.
module pin_state_mode_control #(
	parameter integer POR_CYCLES = `PSM_POR_CYCLES,
	parameter integer PORT_W = 16
) (
	input wire CLK_SYS_I,
	input wire RESETN_I,
	input wire SUPPLY_OK_I,
	input wire EXT_RESETN_I,
	input wire INT_RESET_I,
	input wire [1:0] STANDBY_MODE_I,
	input wire DMA_ACTIVE_I,
	input wire BUS_MUX_MODE_I,
	input wire BUS_CYCLE_I,
	input wire BUS_IDLE_I,
	input wire [1:0] BUS_TSTATE_I,
	input wire DEBUG_MODE_SELECT_BIT_I,
	input wire DEBUG_DATA_I,
	input wire [15:0] CORE_ADDR_DATA_I,
	input wire CORE_ADDR_DATA_DRIVE_I,
	input wire [15:0] CORE_ADDR_LOW_I,
	input wire [7:0] CORE_ADDR_HIGH_I,
	input wire [3:0] CORE_CHIP_SELECT_I,
	input wire [1:0] CORE_WRITE_STROBES_I,
	input wire CORE_READ_STROBE_I,
	input wire CORE_ADDR_LATCH_STROBE_I,
	input wire CORE_CLOCK_OUT_I,
	input wire [1:0] ANALOG_ENABLE_I,
	input wire [PORT_W-1:0] PORT_VAL_I,
	input wire [PORT_W-1:0] PORT_DRIVE_I,
	input wire [PORT_W-1:0] ALT_ACTIVE_I,
	input wire HOLD_REQUEST_I,
	input wire WAIT_I,
	output reg [15:0] BUS_ADDR_DATA_LINES_O,
	output reg BUS_ADDR_DATA_OE_N_O,
	output reg [15:0] BUS_ADDR_LOW_LINES_O,
	output reg [7:0] BUS_ADDR_HIGH_LINES_O,
	output reg BUS_ADDR_OE_N_O,
	output reg [3:0] CHIP_SELECT_LINES_O,
	output reg CHIP_SELECT_OE_N_O,
	output reg [1:0] WRITE_STROBES_O,
	output reg READ_STROBE_O,
	output reg ADDR_LATCH_STROBE_O,
	output reg STROBE_OE_N_O,
	output reg CLOCK_OUTPUT_PIN_O,
	output reg CLOCK_OUTPUT_OE_N_O,
	output reg HOLD_ACKNOWLEDGE_O,
	output reg HOLD_ACKNOWLEDGE_OE_N_O,
	output reg DEBUG_DATA_OUT_O,
	output reg DEBUG_DATA_OUT_OE_N_O,
	output reg DEBUG_RESET_PULLDOWN_O,
	output reg [1:0] ANALOG_OUTPUT_OE_N_O,
	output reg [PORT_W-1:0] PORT_O,
	output reg [PORT_W-1:0] PORT_OE_N_O,
	output reg WAIT_SAMPLED_O,
	output reg HOLD_REQUEST_SAMPLED_O,
	output reg BUS_HOLD_O
);

	localparam ST_POWER_ON = `PSM_ST_POWER_ON;
	localparam ST_EXT_RESET = `PSM_ST_EXT_RESET;
	localparam ST_INT_RESET = `PSM_ST_INT_RESET;
	localparam ST_RUN = `PSM_ST_RUN;
	localparam ST_HALT = `PSM_ST_HALT;
	localparam ST_IDLE = `PSM_ST_IDLE;
	localparam ST_STOP = `PSM_ST_STOP;
	localparam ST_HOLD = `PSM_ST_HOLD;

	reg [3:0] meta;
	reg [3:0] sync;
	reg [31:0] power_cnt;
	reg por_done;
	reg [1:0] last_t;
	reg [2:0] state;
	reg [2:0] next_state;
	wire supply_s;
	wire ext_rst_s;
	wire hreq_s;
	wire wait_s;
	wire bus_idle;
	wire wait_sample;
	wire hold_sample;

	reg [15:0] next_ad;
	reg next_ad_oe_n;
	reg [15:0] next_al;
	reg [7:0] next_ah;
	reg next_addr_oe_n;
	reg [3:0] next_cs;
	reg next_cs_oe_n;
	reg [1:0] next_wr;
	reg next_rd;
	reg next_addr_latch_strobe;
	reg next_strb_oe_n;
	reg next_clk;
	reg next_clk_oe_n;
	reg next_hold_acknowledge;
	reg next_hold_acknowledge_oe_n;
	reg next_dbg;
	reg next_dbg_oe_n;
	reg next_pd;
	reg [1:0] next_ana_oe_n;
	reg [PORT_W-1:0] next_port;
	reg [PORT_W-1:0] next_port_oe_n;

	// Pin inputs, two stages; only sync is read by logic
	always @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			meta <= 4'h0;
			sync <= 4'h0;
		end else begin
			meta <= {SUPPLY_OK_I, ~EXT_RESETN_I, HOLD_REQUEST_I, WAIT_I};
			sync <= meta;
		end
	end
	assign supply_s = sync[3];
	assign ext_rst_s = sync[2];
	assign hreq_s = sync[1];
	assign wait_s = sync[0];

	// settle timer
	// Restarts whenever supply drops out of range
	always @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			power_cnt <= 32'h0;
			por_done <= 1'b0;
		end else if (!supply_s) begin
			power_cnt <= 32'h0;
			por_done <= 1'b0;
		end else if (!por_done) begin
			if (power_cnt == POR_CYCLES - 1)
				por_done <= 1'b1;
			else
				power_cnt <= power_cnt + 32'h1;
		end
	end

	// Last T-state of a bus cycle, to qualify the idle state
	always @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I)
			last_t <= `PSM_T1;
		else if (BUS_CYCLE_I)
			last_t <= BUS_TSTATE_I;
	end

	assign bus_idle = BUS_IDLE_I & (BUS_MUX_MODE_I ?
		(last_t == `PSM_T3) : (last_t == `PSM_T2));

	assign wait_sample = (state == ST_RUN) & ~bus_idle;
	assign hold_sample = ((state == ST_RUN) & ~bus_idle) |
		(state == ST_HALT) | (state == ST_HOLD);

	// Mode priority: power-on, reset, hold, standby
	always @* begin
		next_state = ST_RUN;
		if (!por_done)
			next_state = ST_POWER_ON;
		else if (ext_rst_s)
			next_state = ST_EXT_RESET;
		else if (INT_RESET_I)
			next_state = ST_INT_RESET;
		else if ((state == ST_HOLD) & hreq_s)
			next_state = ST_HOLD;
		else if (hold_sample & hreq_s & ~BUS_CYCLE_I & (state != ST_HOLD))
			next_state = ST_HOLD;
		else begin
			case (STANDBY_MODE_I)
				`PSM_SB_HALT: next_state = ST_HALT;
				`PSM_SB_IDLE: next_state = ST_IDLE;
				`PSM_SB_STOP: next_state = ST_STOP;
				default: next_state = ST_RUN;
			endcase
		end
	end

	always @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I)
			state <= ST_POWER_ON;
		else
			state <= next_state;
	end

	// Pin decode; defaults keep the current level, except clock out, hold acknowledge and alternate port bits
	always @* begin
		next_ad = BUS_ADDR_DATA_LINES_O;
		next_ad_oe_n = BUS_ADDR_DATA_OE_N_O;
		next_al = BUS_ADDR_LOW_LINES_O;
		next_ah = BUS_ADDR_HIGH_LINES_O;
		next_addr_oe_n = BUS_ADDR_OE_N_O;
		next_cs = CHIP_SELECT_LINES_O;
		next_cs_oe_n = CHIP_SELECT_OE_N_O;
		next_wr = WRITE_STROBES_O;
		next_rd = READ_STROBE_O;
		next_addr_latch_strobe = ADDR_LATCH_STROBE_O;
		next_strb_oe_n = STROBE_OE_N_O;
		next_clk = CORE_CLOCK_OUT_I;
		next_clk_oe_n = 1'b0;
		next_hold_acknowledge = 1'b1;
		next_hold_acknowledge_oe_n = 1'b0;
		next_dbg = DEBUG_DATA_OUT_O;
		next_dbg_oe_n = DEBUG_DATA_OUT_OE_N_O;
		next_pd = DEBUG_RESET_PULLDOWN_O;
		next_ana_oe_n = ANALOG_OUTPUT_OE_N_O;
		next_port = (ALT_ACTIVE_I & PORT_VAL_I) |
			(~ALT_ACTIVE_I & PORT_O);
		next_port_oe_n = (ALT_ACTIVE_I & ~PORT_DRIVE_I) |
			(~ALT_ACTIVE_I & PORT_OE_N_O);
		if (DEBUG_MODE_SELECT_BIT_I) begin
			next_dbg = DEBUG_DATA_I;
			next_dbg_oe_n = 1'b0;
		end
		if (ANALOG_ENABLE_I[0])
			next_ana_oe_n[0] = 1'b0;
		if (ANALOG_ENABLE_I[1])
			next_ana_oe_n[1] = 1'b0;
		case (state)
			ST_POWER_ON, ST_EXT_RESET, ST_INT_RESET: begin
				next_ad_oe_n = 1'b1;
				next_addr_oe_n = 1'b1;
				next_cs_oe_n = 1'b1;
				next_strb_oe_n = 1'b1;
				next_clk_oe_n = 1'b1;
				next_hold_acknowledge_oe_n = 1'b1;
				next_port_oe_n = {PORT_W{1'b1}};
				next_ana_oe_n = 2'h3;
				next_dbg_oe_n = 1'b1;
				next_pd = (state == ST_INT_RESET) ?
					~DEBUG_MODE_SELECT_BIT_I : 1'b1;
			end
			ST_RUN: begin
				next_pd = ~DEBUG_MODE_SELECT_BIT_I;
				next_port = PORT_VAL_I;
				next_port_oe_n = ~PORT_DRIVE_I;
				next_ana_oe_n = ~ANALOG_ENABLE_I;
				if (!DEBUG_MODE_SELECT_BIT_I)
					next_dbg_oe_n = 1'b1;
				next_strb_oe_n = 1'b0;
				next_cs_oe_n = 1'b0;
				next_addr_oe_n = 1'b0;
				if (bus_idle) begin
					next_wr = 2'h3;
					next_rd = 1'b1;
					next_addr_latch_strobe = 1'b1;
				end else begin
					next_ad = CORE_ADDR_DATA_I;
					next_ad_oe_n = ~CORE_ADDR_DATA_DRIVE_I;
					next_al = CORE_ADDR_LOW_I;
					next_ah = CORE_ADDR_HIGH_I;
					next_cs = CORE_CHIP_SELECT_I;
					next_wr = CORE_WRITE_STROBES_I;
					next_rd = CORE_READ_STROBE_I;
					next_addr_latch_strobe = CORE_ADDR_LATCH_STROBE_I;
				end
			end
			ST_HALT: begin
				if (DMA_ACTIVE_I) begin
					next_ad = CORE_ADDR_DATA_I;
					next_ad_oe_n = ~CORE_ADDR_DATA_DRIVE_I;
					next_al = CORE_ADDR_LOW_I;
					next_ah = CORE_ADDR_HIGH_I;
					next_addr_oe_n = 1'b0;
					next_cs = CORE_CHIP_SELECT_I;
					next_wr = CORE_WRITE_STROBES_I;
					next_rd = CORE_READ_STROBE_I;
					next_addr_latch_strobe = CORE_ADDR_LATCH_STROBE_I;
				end else begin
					next_wr = 2'h3;
					next_rd = 1'b1;
					next_addr_latch_strobe = 1'b1;
					next_cs = 4'hf;
					// separate floats, multiplexed left as is
					if (!BUS_MUX_MODE_I)
						next_ad_oe_n = 1'b1;
				end
				next_strb_oe_n = 1'b0;
				next_cs_oe_n = 1'b0;
			end
			ST_IDLE, ST_STOP: begin
				next_clk = 1'b0;
				next_wr = 2'h3;
				next_rd = 1'b1;
				next_addr_latch_strobe = 1'b1;
				next_strb_oe_n = 1'b0;
				next_cs = 4'hf;
				next_cs_oe_n = 1'b0;
				next_ad_oe_n = 1'b1;
				next_addr_oe_n = 1'b1;
				if (state == ST_STOP)
					next_ana_oe_n = 2'h3;
			end
			ST_HOLD: begin
				next_hold_acknowledge = 1'b0;
				next_ad_oe_n = 1'b1;
				next_addr_oe_n = 1'b1;
				next_cs_oe_n = 1'b1;
				next_strb_oe_n = 1'b1;
				// Held ports do not follow alternates here
				next_port = PORT_O;
				next_port_oe_n = PORT_OE_N_O;
			end
			default: begin
				next_ad_oe_n = 1'b1;
			end
		endcase
	end

	// Pin registers; reset shows the power-on state
	always @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			BUS_ADDR_DATA_LINES_O <= 16'h0;
			BUS_ADDR_DATA_OE_N_O <= 1'b1;
			BUS_ADDR_LOW_LINES_O <= 16'h0;
			BUS_ADDR_HIGH_LINES_O <= 8'h0;
			BUS_ADDR_OE_N_O <= 1'b1;
			CHIP_SELECT_LINES_O <= 4'hf;
			CHIP_SELECT_OE_N_O <= 1'b1;
			WRITE_STROBES_O <= 2'h3;
			READ_STROBE_O <= 1'b1;
			ADDR_LATCH_STROBE_O <= 1'b1;
			STROBE_OE_N_O <= 1'b1;
			CLOCK_OUTPUT_PIN_O <= 1'b0;
			CLOCK_OUTPUT_OE_N_O <= 1'b1;
			HOLD_ACKNOWLEDGE_O <= 1'b1;
			HOLD_ACKNOWLEDGE_OE_N_O <= 1'b1;
			DEBUG_DATA_OUT_O <= 1'b0;
			DEBUG_DATA_OUT_OE_N_O <= 1'b1;
			DEBUG_RESET_PULLDOWN_O <= 1'b1;
			ANALOG_OUTPUT_OE_N_O <= 2'h3;
			PORT_O <= {PORT_W{1'b0}};
			PORT_OE_N_O <= {PORT_W{1'b1}};
			WAIT_SAMPLED_O <= 1'b0;
			HOLD_REQUEST_SAMPLED_O <= 1'b0;
			BUS_HOLD_O <= 1'b0;
		end else begin
			BUS_ADDR_DATA_LINES_O <= next_ad;
			BUS_ADDR_DATA_OE_N_O <= next_ad_oe_n;
			BUS_ADDR_LOW_LINES_O <= next_al;
			BUS_ADDR_HIGH_LINES_O <= next_ah;
			BUS_ADDR_OE_N_O <= next_addr_oe_n;
			CHIP_SELECT_LINES_O <= next_cs;
			CHIP_SELECT_OE_N_O <= next_cs_oe_n;
			WRITE_STROBES_O <= next_wr;
			READ_STROBE_O <= next_rd;
			ADDR_LATCH_STROBE_O <= next_addr_latch_strobe;
			STROBE_OE_N_O <= next_strb_oe_n;
			CLOCK_OUTPUT_PIN_O <= next_clk;
			CLOCK_OUTPUT_OE_N_O <= next_clk_oe_n;
			HOLD_ACKNOWLEDGE_O <= next_hold_acknowledge;
			HOLD_ACKNOWLEDGE_OE_N_O <= next_hold_acknowledge_oe_n;
			DEBUG_DATA_OUT_O <= next_dbg;
			DEBUG_DATA_OUT_OE_N_O <= next_dbg_oe_n;
			DEBUG_RESET_PULLDOWN_O <= next_pd;
			ANALOG_OUTPUT_OE_N_O <= next_ana_oe_n;
			PORT_O <= next_port;
			PORT_OE_N_O <= next_port_oe_n;
			WAIT_SAMPLED_O <= wait_s & wait_sample;
			HOLD_REQUEST_SAMPLED_O <= hreq_s & hold_sample;
			BUS_HOLD_O <= (next_state == ST_HOLD);
		end
	end

endmodule

// >>> verification/pin_state_mode_control_monitor.sv
// Purpose: Port-level checks for the pin state controller.
// Assumes: Bench holds mode inputs steady for several cycles.
// Notes: Power-on span is counted here on the raw supply input.
`timescale 1ns/1ns
module pin_state_monitor #(
	parameter integer POR_CYCLES = 20
) (
	input wire CLK_SYS_I,
	input wire RESETN_I,
	input wire SUPPLY_OK_I,
	input wire EXT_RESETN_I,
	input wire INT_RESET_I,
	input wire [1:0] STANDBY_MODE_I,
	input wire DMA_ACTIVE_I,
	input wire BUS_MUX_MODE_I,
	input wire BUS_CYCLE_I,
	input wire BUS_IDLE_I,
	input wire DEBUG_MODE_SELECT_BIT_I,
	input wire HOLD_REQUEST_I,
	input wire BUS_ADDR_DATA_OE_N_O,
	input wire BUS_ADDR_OE_N_O,
	input wire [3:0] CHIP_SELECT_LINES_O,
	input wire CHIP_SELECT_OE_N_O,
	input wire [1:0] WRITE_STROBES_O,
	input wire READ_STROBE_O,
	input wire ADDR_LATCH_STROBE_O,
	input wire STROBE_OE_N_O,
	input wire CLOCK_OUTPUT_PIN_O,
	input wire CLOCK_OUTPUT_OE_N_O,
	input wire HOLD_ACKNOWLEDGE_O,
	input wire DEBUG_DATA_OUT_OE_N_O,
	input wire DEBUG_RESET_PULLDOWN_O,
	input wire [1:0] ANALOG_OUTPUT_OE_N_O,
	input wire [15:0] PORT_OE_N_O,
	input wire WAIT_SAMPLED_O,
	input wire HOLD_REQUEST_SAMPLED_O,
	input wire BUS_HOLD_O
);
	integer cnt;
	wire ok;
	wire flt;
	wire strb;
	// Raw supply count; the design counts later, so this never falls behind it
	always @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I)
			cnt <= 0;
		else if (SUPPLY_OK_I && cnt < POR_CYCLES + 8)
			cnt <= cnt + 1;
	end
	// Settled run conditions and common pin groups
	assign ok = cnt >= POR_CYCLES + 8 && EXT_RESETN_I && !INT_RESET_I;
	assign flt = BUS_ADDR_DATA_OE_N_O && BUS_ADDR_OE_N_O && STROBE_OE_N_O
		&& CHIP_SELECT_OE_N_O;
	assign strb = &WRITE_STROBES_O && READ_STROBE_O && ADDR_LATCH_STROBE_O
		&& &CHIP_SELECT_LINES_O;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESETN_I);
	sequence s_held;
		BUS_HOLD_O ##1 BUS_HOLD_O;
	endsequence
	sequence s_req;
		(HOLD_REQUEST_I && ok && STANDBY_MODE_I == 2'h0 && !BUS_CYCLE_I
			&& !BUS_IDLE_I)[*4];
	endsequence
	chk_por_float: assert property (
		cnt < POR_CYCLES |-> flt && DEBUG_RESET_PULLDOWN_O && &PORT_OE_N_O
	) else $error("pins driven during power-on");
	chk_ext_reset: assert property (
		(!EXT_RESETN_I)[*6] |-> flt && DEBUG_RESET_PULLDOWN_O
			&& DEBUG_DATA_OUT_OE_N_O
	) else $error("external reset pin states wrong");
	chk_int_debug: assert property (
		(INT_RESET_I && EXT_RESETN_I && cnt >= POR_CYCLES + 8
			&& $stable(DEBUG_MODE_SELECT_BIT_I))[*5]
		|-> flt && DEBUG_DATA_OUT_OE_N_O
			&& DEBUG_RESET_PULLDOWN_O == !DEBUG_MODE_SELECT_BIT_I
	) else $error("internal reset debug pins wrong");
	chk_hold_pins: assert property (
		s_held |-> !HOLD_ACKNOWLEDGE_O && flt
	) else $error("bus hold pins wrong");
	chk_hold_entry: assert property (
		s_req |-> ##[0:2] BUS_HOLD_O
	) else $error("hold request not granted");
	chk_no_sample: assert property (
		(STANDBY_MODE_I[1] && ok)[*4]
		|-> !HOLD_REQUEST_SAMPLED_O && !WAIT_SAMPLED_O
	) else $error("input sampled in deep standby");
	chk_deep_standby: assert property (
		(STANDBY_MODE_I[1] && ok && !BUS_HOLD_O
			&& $stable(STANDBY_MODE_I))[*5]
		|-> !CLOCK_OUTPUT_PIN_O && !CLOCK_OUTPUT_OE_N_O && strb
			&& !STROBE_OE_N_O && BUS_ADDR_DATA_OE_N_O
			&& (!STANDBY_MODE_I[0] || &ANALOG_OUTPUT_OE_N_O)
	) else $error("idle or stop pin states wrong");
	chk_halt_idle: assert property (
		(STANDBY_MODE_I == 2'h1 && !DMA_ACTIVE_I && ok && !BUS_HOLD_O
			&& $stable(BUS_MUX_MODE_I))[*5]
		|-> strb && HOLD_ACKNOWLEDGE_O
			&& (BUS_MUX_MODE_I || BUS_ADDR_DATA_OE_N_O)
	) else $error("halt pin states wrong");
	chk_debug_float: assert property (
		(!DEBUG_MODE_SELECT_BIT_I && ok && STANDBY_MODE_I == 2'h0)[*4]
		|-> DEBUG_DATA_OUT_OE_N_O
	) else $error("debug data driven outside debug mode");
endmodule
bind pin_state_mode_control pin_state_monitor #(
	.POR_CYCLES(POR_CYCLES)
) mon (.*);

// >>> verification/hold_requester_model.sv
// Purpose: Far side: bus-hold requester and slow external memory.
// Assumes: Driven on the bench clock, changes just after the edge.
// Notes: A wait length of zero gives a prompt memory.
`timescale 1ns/1ns
module hold_requester_model (
	input wire clk_i,
	input wire rstn_i,
	input wire want_hold_i,
	input wire bus_cycle_i,
	input wire [3:0] wait_len_i,
	output reg hold_request_o,
	output reg wait_o
);
	reg [3:0] left;
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			hold_request_o <= 1'h0;
		else
			hold_request_o <= want_hold_i;
	end
	// Stretch each bus cycle; the count keeps running past its end
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			left <= 4'h0;
			wait_o <= 1'h0;
		end else begin
			if (bus_cycle_i && left == 4'h0 && !wait_o)
				left <= wait_len_i;
			else if (left != 4'h0)
				left <= left - 4'h1;
			wait_o <= left != 4'h0;
		end
	end
endmodule

// >>> verification/pin_state_mode_control_tb_top.sv
// Purpose: Self-checking bench for the pin state controller.
// Assumes: Power-on span shortened to 20 cycles.
// Notes: Outputs are read at the edge, before that edge's updates land.
`timescale 1ns/1ns
module pin_state_mode_control_tb_top;
	logic CLK_SYS_I = 1'h0, RESETN_I = 1'h0, SUPPLY_OK_I = 1'h0;
	logic EXT_RESETN_I = 1'h1, INT_RESET_I = 1'h0, DMA_ACTIVE_I = 1'h0;
	logic BUS_MUX_MODE_I = 1'h0, BUS_CYCLE_I = 1'h0, BUS_IDLE_I = 1'h0;
	logic DEBUG_MODE_SELECT_BIT_I = 1'h0, DEBUG_DATA_I = 1'h0;
	logic CORE_ADDR_DATA_DRIVE_I = 1'h0, CORE_READ_STROBE_I = 1'h0;
	logic CORE_ADDR_LATCH_STROBE_I = 1'h0, CORE_CLOCK_OUT_I = 1'h0;
	logic want_hold = 1'h0, c;
	logic [1:0] STANDBY_MODE_I = 2'h0, BUS_TSTATE_I = 2'h0;
	logic [1:0] CORE_WRITE_STROBES_I = 2'h0, ANALOG_ENABLE_I = 2'h0;
	logic [3:0] CORE_CHIP_SELECT_I = 4'h0, wait_len = 4'h0;
	logic [7:0] CORE_ADDR_HIGH_I = 8'h0;
	logic [15:0] CORE_ADDR_DATA_I = 16'h0, CORE_ADDR_LOW_I = 16'h0;
	logic [15:0] PORT_VAL_I = 16'h0, PORT_DRIVE_I = 16'hffff;
	logic [15:0] ALT_ACTIVE_I = 16'h0, pv, w, cs, ad, dv, al;
	wire [15:0] BUS_ADDR_DATA_LINES_O, BUS_ADDR_LOW_LINES_O, PORT_O;
	wire [15:0] PORT_OE_N_O;
	wire [7:0] BUS_ADDR_HIGH_LINES_O;
	wire [3:0] CHIP_SELECT_LINES_O;
	wire [1:0] WRITE_STROBES_O, ANALOG_OUTPUT_OE_N_O;
	wire BUS_ADDR_DATA_OE_N_O, BUS_ADDR_OE_N_O, CHIP_SELECT_OE_N_O;
	wire READ_STROBE_O, ADDR_LATCH_STROBE_O, STROBE_OE_N_O;
	wire CLOCK_OUTPUT_PIN_O, CLOCK_OUTPUT_OE_N_O, HOLD_ACKNOWLEDGE_O;
	wire HOLD_ACKNOWLEDGE_OE_N_O, DEBUG_DATA_OUT_O, DEBUG_DATA_OUT_OE_N_O;
	wire DEBUG_RESET_PULLDOWN_O, WAIT_SAMPLED_O, HOLD_REQUEST_SAMPLED_O;
	wire BUS_HOLD_O, HOLD_REQUEST_I, WAIT_I;
	integer n_errors = 0, comparisons = 0, m, n;

	pin_state_mode_control #(.POR_CYCLES(20), .PORT_W(16)) uut (.*);
	hold_requester_model far (
		.clk_i(CLK_SYS_I),
		.rstn_i(RESETN_I),
		.want_hold_i(want_hold),
		.bus_cycle_i(BUS_CYCLE_I),
		.wait_len_i(wait_len),
		.hold_request_o(HOLD_REQUEST_I),
		.wait_o(WAIT_I)
	);

	// Clock and a free-running clock-out source
	always #5 CLK_SYS_I = ~CLK_SYS_I;
	always @(posedge CLK_SYS_I) CORE_CLOCK_OUT_I <= ~CORE_CLOCK_OUT_I;

	task cyc(input integer k);
		repeat (k) @(posedge CLK_SYS_I);
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Held bits keep the old level, alternate bits keep working
	function logic [15:0] pexp(input logic [15:0] h, v, a);
		return (h & ~a) | (v & a);
	endfunction
	task rnd;
		CORE_ADDR_DATA_I <= 16'($urandom);
		CORE_ADDR_LOW_I <= 16'($urandom);
		CORE_ADDR_HIGH_I <= 8'($urandom);
		CORE_CHIP_SELECT_I <= 4'($urandom);
		CORE_WRITE_STROBES_I <= 2'($urandom);
		CORE_READ_STROBE_I <= 1'($urandom);
		CORE_ADDR_LATCH_STROBE_I <= 1'($urandom);
		CORE_ADDR_DATA_DRIVE_I <= 1'($urandom);
		ANALOG_ENABLE_I <= 2'($urandom);
		DEBUG_DATA_I <= 1'($urandom);
		PORT_VAL_I <= 16'($urandom);
		PORT_DRIVE_I <= 16'($urandom);
		ALT_ACTIVE_I <= 16'($urandom);
	endtask
	task final_report;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog, far beyond the expected run of about 200 cycles
	initial begin
		#20000;
		n_errors++;
		final_report;
	end

	// Main sequence
	initial begin
		void'($urandom(32'ha16fb504));
		cyc(2);
		RESETN_I <= 1'h1;
		cyc(4);
		chk(BUS_ADDR_DATA_OE_N_O, 1'h1);
		SUPPLY_OK_I <= 1'h1;
		cyc(10);
		chk(CLOCK_OUTPUT_OE_N_O, 1'h1);
		chk(DEBUG_RESET_PULLDOWN_O, 1'h1);
		cyc(20);
		chk(HOLD_ACKNOWLEDGE_OE_N_O, 1'h0);
		for (m = 0; m < 2; m++) begin
			BUS_MUX_MODE_I <= m[0];
			rnd();
			BUS_CYCLE_I <= 1'h1;
			BUS_TSTATE_I <= 2'h0;
			cyc(1);
			BUS_TSTATE_I <= m[0] ? 2'h2 : 2'h1;
			cyc(3);
			cs = 16'(CORE_CHIP_SELECT_I);
			ad = CORE_ADDR_DATA_I;
			al = CORE_ADDR_LOW_I;
			BUS_CYCLE_I <= 1'h0;
			BUS_IDLE_I <= 1'h1;
			rnd();
			cyc(4);
			chk(CHIP_SELECT_LINES_O, cs);
			chk(BUS_ADDR_DATA_LINES_O, ad);
			chk(BUS_ADDR_LOW_LINES_O, al);
			chk({WRITE_STROBES_O, READ_STROBE_O, ADDR_LATCH_STROBE_O}, 4'hf);
			c = CLOCK_OUTPUT_PIN_O;
			cyc(1);
			chk(CLOCK_OUTPUT_PIN_O, !c);
			BUS_IDLE_I <= 1'h0;
		end
		pv = PORT_VAL_I;
		want_hold <= 1'h1;
		for (n = 0; n < 12 && BUS_HOLD_O !== 1'h1; n++)
			cyc(1);
		rnd();
		cyc(3);
		chk(HOLD_ACKNOWLEDGE_O, 1'h0);
		chk(HOLD_REQUEST_SAMPLED_O, 1'h1);
		chk(PORT_O, pv);
		want_hold <= 1'h0;
		cyc(6);
		chk(BUS_HOLD_O, 1'h0);
		BUS_MUX_MODE_I <= 1'h0;
		BUS_TSTATE_I <= 2'h1;
		BUS_CYCLE_I <= 1'h1;
		wait_len <= 4'hf;
		for (n = 0; n < 12 && WAIT_SAMPLED_O !== 1'h1; n++)
			cyc(1);
		chk(WAIT_SAMPLED_O, 1'h1);
		BUS_CYCLE_I <= 1'h0;
		BUS_IDLE_I <= 1'h1;
		wait_len <= 4'h0;
		cyc(4);
		chk(WAIT_SAMPLED_O, 1'h0);
		BUS_IDLE_I <= 1'h0;
		for (m = 1; m < 4; m++) begin
			rnd();
			cyc(3);
			pv = PORT_VAL_I;
			dv = PORT_DRIVE_I;
			STANDBY_MODE_I <= m[1:0];
			cyc(4);
			w = 16'($urandom);
			PORT_VAL_I <= w;
			// Flip drive so held and alternate enables differ
			PORT_DRIVE_I <= ~dv;
			cyc(4);
			chk(PORT_O, pexp(pv, w, ALT_ACTIVE_I));
			chk(PORT_OE_N_O, pexp(~dv, dv, ALT_ACTIVE_I));
			// Sized so the inversion stays two bits wide
			chk(ANALOG_OUTPUT_OE_N_O,
				2'(m == 3 ? 2'h3 : ~ANALOG_ENABLE_I));
			DMA_ACTIVE_I <= m == 1;
			cyc(4);
			if (m == 1)
				chk(WRITE_STROBES_O, CORE_WRITE_STROBES_I);
			STANDBY_MODE_I <= 2'h0;
			DMA_ACTIVE_I <= 1'h0;
			cyc(4);
		end
		for (m = 0; m < 2; m++) begin
			DEBUG_MODE_SELECT_BIT_I <= m[0];
			// Bit settles first so the checker's stable window opens
			cyc(1);
			INT_RESET_I <= 1'h1;
			cyc(5);
			chk(DEBUG_RESET_PULLDOWN_O, !m[0]);
			chk(DEBUG_DATA_OUT_OE_N_O, 1'h1);
			chk(BUS_ADDR_OE_N_O, 1'h1);
			INT_RESET_I <= 1'h0;
			cyc(4);
		end
		rnd();
		cyc(3);
		chk(DEBUG_DATA_OUT_OE_N_O, 1'h0);
		chk(DEBUG_DATA_OUT_O, DEBUG_DATA_I);
		EXT_RESETN_I <= 1'h0;
		cyc(6);
		chk(DEBUG_RESET_PULLDOWN_O, 1'h1);
		chk(STROBE_OE_N_O, 1'h1);
		EXT_RESETN_I <= 1'h1;
		cyc(6);
		RESETN_I <= 1'h0;
		cyc(2);
		RESETN_I <= 1'h1;
		cyc(3);
		chk(CHIP_SELECT_OE_N_O, 1'h1);
		cyc(30);
		final_report;
	end
endmodule
